// file: verilog/conv_unit.v
// time and bit-column conversion unit with wishbone registers
// assumes a data memory that answers each access with ack or err
//
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "conv_unit_defs.vh"

module conv_unit #(
  parameter ADDR_W = 16,
  parameter AREA_W = 3
) (
  // clock and reset
  input  wire              clk_i,
  input  wire              rst_i,
  // wishbone slave
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [7:0]        wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  // data memory master
  output reg               mem_cyc_o,
  output reg               mem_we_o,
  output reg  [ADDR_W-1:0] mem_adr_o,
  output reg  [15:0]       mem_dat_o,
  input  wire [15:0]       mem_dat_i,
  input  wire              mem_ack_i,
  input  wire              mem_err_i
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE  = 3'h0;
  localparam ST_CHK   = 3'h1;
  localparam ST_ISSUE = 3'h2;
  localparam ST_WAIT  = 3'h3;
  localparam ST_EVAL  = 3'h4;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function is_bcd;
    input [15:0] w;
    begin
      is_bcd = (w[3:0] < 4'ha) && (w[7:4] < 4'ha) &&
               (w[11:8] < 4'ha) && (w[15:12] < 4'ha);
    end
  endfunction

  function [13:0] bcd2bin;
    input [15:0] w;
    begin
      bcd2bin = {4'h0, w[15:12]} * 14'h03e8 + {4'h0, w[11:8]} * 14'h0064 +
                {4'h0, w[7:4]} * 14'h000a + {10'h000, w[3:0]};
    end
  endfunction

  // shift-add-3; inputs stay within eight decimal digits
  function [31:0] bin2bcd;
    input [26:0] b;
    integer i;
    integer j;
    reg [31:0] d;
    begin
      d = 32'h0;
      for (i = 26; i >= 0; i = i - 1) begin
        for (j = 0; j < 8; j = j + 1) begin
          if (d[j*4 +: 4] > 4'h4)
            d[j*4 +: 4] = d[j*4 +: 4] + 4'h3;
        end
        d = {d[30:0], b[i]};
      end
      bin2bcd = d;
    end
  endfunction

  // area is the top address bits; wrapping past the top also counts
  function same_area;
    input [ADDR_W-1:0] a;
    input [4:0]        n;
    reg   [ADDR_W:0]   s;
    begin
      s = {1'b0, a} + {{(ADDR_W-4){1'b0}}, n};
      same_area = !s[ADDR_W] &&
                  (s[ADDR_W-1 -: AREA_W] == a[ADDR_W-1 -: AREA_W]);
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [2:0]        state_r;
  reg [1:0]        op_r;
  reg [ADDR_W-1:0] src_r;
  reg [ADDR_W-1:0] dst_r;
  reg [15:0]       col_r;
  reg              err_r;
  reg              zero_r;
  reg              wr_r;
  reg [3:0]        cnt_r;
  reg [15:0]       w0_r;
  reg [15:0]       w1_r;
  reg [15:0]       acc_r;
  reg [15:0]       res0_r;
  reg [15:0]       res1_r;

  // ----------------------------------------
  // wishbone decode
  // ----------------------------------------
  wire       wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire       wb_wr  = wb_req && wb_we_i;
  wire       busy   = (state_r != ST_IDLE);
  wire       go     = wb_wr && (wb_adr_i == `OFS_CTRL) && wb_sel_i[0] &&
                      wb_dat_i[`CTRL_GO_BIT] && !busy;
  wire [1:0] go_op  = wb_dat_i[`CTRL_OP_LSB +: 2];

  reg [31:0] rd_nxt;

  always @* begin
    rd_nxt = 32'h0;
    if (wb_adr_i == `OFS_SRC) begin
      rd_nxt = {{(32-ADDR_W){1'b0}}, src_r};
    end else if (wb_adr_i == `OFS_DST) begin
      rd_nxt = {{(32-ADDR_W){1'b0}}, dst_r};
    end else if (wb_adr_i == `OFS_COL) begin
      rd_nxt = {16'h0, col_r};
    end else if (wb_adr_i == `OFS_STATUS) begin
      rd_nxt[`STAT_BUSY_BIT] = busy;
      rd_nxt[`STAT_ERR_BIT]  = err_r;
      rd_nxt[`STAT_ZERO_BIT] = zero_r;
    end else if (wb_adr_i == `OFS_CTRL) begin
      rd_nxt = {30'h0, op_r};
    end
  end

  // one wait state per access; unmapped reads give zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_nxt : 32'h0;
    end
  end

  // ----------------------------------------
  // operand checks
  // ----------------------------------------
  wire [13:0] col_bin = bcd2bin(col_r);
  wire        col_ok  = is_bcd(col_r) && (col_bin <= `COL_MAX);
  wire        pre_err = (op_r == `OP_COL) ?
                        (!col_ok || !same_area(src_r, 5'h0f)) :
                        (!same_area(src_r, 5'h01) ||
                         !same_area(dst_r, 5'h01));
  wire        last_rd = (op_r == `OP_COL) ? (cnt_r == 4'hf) :
                                             (cnt_r == 4'h1);
  wire        last_wr = (op_r == `OP_COL) || (cnt_r == 4'h1);

  // ----------------------------------------
  // arithmetic
  // ----------------------------------------
  reg [26:0] total;
  reg [26:0] hrs;
  reg [26:0] rem;
  reg [26:0] mins;
  reg [26:0] secs;
  reg [31:0] bcd_t;
  reg [31:0] bcd_h;
  reg [31:0] bcd_m;
  reg [31:0] bcd_s;
  reg        ev_err;
  reg [15:0] ev_r0;
  reg [15:0] ev_r1;

  always @* begin
    total  = 27'h0;
    hrs    = 27'h0;
    rem    = 27'h0;
    mins   = 27'h0;
    secs   = 27'h0;
    bcd_t  = 32'h0;
    bcd_h  = 32'h0;
    bcd_m  = 32'h0;
    bcd_s  = 32'h0;
    ev_err = 1'b0;
    ev_r0  = acc_r;
    ev_r1  = 16'h0;
    if (op_r == `OP_H2S) begin
      // hours word is four bcd digits, so 9999 hours is the ceiling
      ev_err = !is_bcd(w0_r) || !is_bcd(w1_r) ||
               (w0_r[7:0] > `BCD_59) || (w0_r[15:8] > `BCD_59);
      total  = {13'h0, bcd2bin(w1_r)} * `SEC_PER_HOUR +
               {13'h0, bcd2bin({8'h00, w0_r[15:8]})} * `SEC_PER_MIN +
               {13'h0, bcd2bin({8'h00, w0_r[7:0]})};
      bcd_t  = bin2bcd(total);
      ev_r0  = bcd_t[15:0];
      ev_r1  = bcd_t[31:16];
    end else if (op_r == `OP_S2H) begin
      total  = {13'h0, bcd2bin(w1_r)} * `TEN_THOUSAND +
               {13'h0, bcd2bin(w0_r)};
      ev_err = !is_bcd(w0_r) || !is_bcd(w1_r) ||
               (total > `TOTAL_MAX);
      hrs    = total / `SEC_PER_HOUR;
      rem    = total % `SEC_PER_HOUR;
      mins   = rem / `SEC_PER_MIN;
      secs   = rem % `SEC_PER_MIN;
      bcd_h  = bin2bcd(hrs);
      bcd_m  = bin2bcd(mins);
      bcd_s  = bin2bcd(secs);
      ev_r0  = {bcd_m[7:0], bcd_s[7:0]};
      ev_r1  = bcd_h[15:0];
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r   <= ST_IDLE;
      op_r      <= `RST_OP;
      src_r     <= `RST_ADDR;
      dst_r     <= `RST_ADDR;
      col_r     <= `RST_COL;
      err_r     <= 1'b0;
      zero_r    <= 1'b0;
      wr_r      <= 1'b0;
      cnt_r     <= 4'h0;
      w0_r      <= 16'h0;
      w1_r      <= 16'h0;
      acc_r     <= 16'h0;
      res0_r    <= 16'h0;
      res1_r    <= 16'h0;
      mem_cyc_o <= 1'b0;
      mem_we_o  <= 1'b0;
      mem_adr_o <= `RST_ADDR;
      mem_dat_o <= 16'h0;
    end else begin
      // operand registers are frozen while an operation runs
      if (wb_wr && !busy) begin
        if (wb_adr_i == `OFS_SRC) begin
          if (wb_sel_i[0]) src_r[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) src_r[ADDR_W-1:8] <= wb_dat_i[ADDR_W-1:8];
        end else if (wb_adr_i == `OFS_DST) begin
          if (wb_sel_i[0]) dst_r[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) dst_r[ADDR_W-1:8] <= wb_dat_i[ADDR_W-1:8];
        end else if (wb_adr_i == `OFS_COL) begin
          if (wb_sel_i[0]) col_r[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) col_r[15:8] <= wb_dat_i[15:8];
        end
      end
      case (state_r)
        ST_IDLE: begin
          if (go) begin
            op_r <= go_op;
            // a false condition leaves flags and memory untouched
            if (!(go_op == `OP_COL && !wb_dat_i[`CTRL_COND_BIT])) begin
              err_r   <= 1'b0;
              state_r <= ST_CHK;
            end
          end
        end
        ST_CHK: begin
          wr_r  <= 1'b0;
          cnt_r <= 4'h0;
          if (pre_err) begin
            err_r   <= 1'b1;
            state_r <= ST_IDLE;
          end else begin
            state_r <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          mem_cyc_o <= 1'b1;
          mem_we_o  <= wr_r;
          mem_adr_o <= (wr_r ? dst_r : src_r) + {{(ADDR_W-4){1'b0}}, cnt_r};
          mem_dat_o <= (cnt_r == 4'h0) ? res0_r : res1_r;
          state_r   <= ST_WAIT;
        end
        ST_WAIT: begin
          if (mem_err_i) begin
            mem_cyc_o <= 1'b0;
            err_r     <= 1'b1;
            state_r   <= ST_IDLE;
          end else if (mem_ack_i) begin
            mem_cyc_o <= 1'b0;
            if (!wr_r) begin
              if (cnt_r == 4'h0) w0_r <= mem_dat_i;
              if (cnt_r == 4'h1) w1_r <= mem_dat_i;
              acc_r[cnt_r] <= mem_dat_i[col_bin[3:0]];
              if (last_rd) begin
                state_r <= ST_EVAL;
              end else begin
                cnt_r   <= cnt_r + 4'h1;
                state_r <= ST_ISSUE;
              end
            end else if (last_wr) begin
              state_r <= ST_IDLE;
            end else begin
              cnt_r   <= cnt_r + 4'h1;
              state_r <= ST_ISSUE;
            end
          end
        end
        ST_EVAL: begin
          cnt_r <= 4'h0;
          if (ev_err) begin
            // nothing written, previous results stay in memory
            err_r   <= 1'b1;
            state_r <= ST_IDLE;
          end else begin
            res0_r  <= ev_r0;
            res1_r  <= ev_r1;
            zero_r  <= (ev_r0 == 16'h0) && (ev_r1 == 16'h0);
            wr_r    <= 1'b1;
            state_r <= ST_ISSUE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // conv_unit

// file: shared/conv_unit_defs.vh
// constants for the time and bit-column conversion unit
// assumes a 32-bit classic wishbone slave and a 16-bit data memory port
`ifndef CONV_UNIT_DEFS_VH
`define CONV_UNIT_DEFS_VH

// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_SRC       8'h04
`define OFS_DST       8'h08
`define OFS_COL       8'h0c
`define OFS_STATUS    8'h10

// control word fields
`define CTRL_OP_LSB   0
`define CTRL_COND_BIT 2
`define CTRL_GO_BIT   3

// operation codes
`define OP_H2S        2'h0
`define OP_S2H        2'h1
`define OP_COL        2'h2

// status word fields
`define STAT_BUSY_BIT 0
`define STAT_ERR_BIT  1
`define STAT_ZERO_BIT 2

// reset values
`define RST_ADDR      16'h0000
`define RST_COL       16'h0000
`define RST_OP        2'h0

// limits
`define BCD_59        8'h59
`define COL_MAX       14'h000f
`define TOTAL_MAX     27'h22550ff
`define SEC_PER_HOUR  27'h0000e10
`define SEC_PER_MIN   27'h000003c
`define TEN_THOUSAND  27'h0002710

`endif

// file: tb/conv_mem_model.sv
// data memory model for the unit's memory port
// assumes one clock; slow_i adds wait cycles, err_adr_i faults
`timescale 1ns/1ps
module conv_mem_model (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // memory port
  input  wire        cyc_i,
  input  wire        we_i,
  input  wire [15:0] adr_i,
  input  wire [15:0] dat_i,
  output reg  [15:0] dat_o,
  output reg         ack_o,
  output reg         err_o,
  // bench controls
  input  wire        slow_i,
  input  wire [15:0] err_adr_i
);
  reg [15:0] mem [0:65535];
  reg [1:0]  wait_r;
  // read data scrambles outside the answer cycle
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    err_o <= 1'b0;
    dat_o <= ~dat_o;
    if (rst_i) begin
      wait_r <= 2'h0;
      dat_o  <= 16'h5a5a;
    end else if (cyc_i && !ack_o && !err_o) begin
      if (wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
      end else if (adr_i == err_adr_i) begin
        err_o <= 1'b1;
      end else begin
        ack_o <= 1'b1;
        dat_o <= mem[adr_i];
        if (we_i) begin
          mem[adr_i] <= dat_i;
        end
      end
    end else begin
      wait_r <= slow_i ? 2'h3 : 2'h0;
    end
  end
endmodule // conv_mem_model

// file: tb/conv_unit_chk.sv
// port assertions for the conversion unit
// assumes bind into conv_unit, one clock, synchronous reset
`timescale 1ns/1ps
module conv_unit_chk #(
  parameter ADDR_W = 16
) (
  // clock and reset
  input wire              clk_i,
  input wire              rst_i,
  // register bus
  input wire              wb_cyc_i,
  input wire              wb_stb_i,
  input wire [31:0]       wb_dat_o,
  input wire              wb_ack_o,
  // memory port
  input wire              mem_cyc_o,
  input wire              mem_we_o,
  input wire [ADDR_W-1:0] mem_adr_o,
  input wire              mem_ack_i,
  input wire              mem_err_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----
  // completed accesses
  // ----
  sequence rd_done;
    mem_cyc_o && !mem_we_o && mem_ack_i && !mem_err_i;
  endsequence
  sequence wr_done;
    mem_cyc_o && mem_we_o && mem_ack_i && !mem_err_i;
  endsequence
  ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  mem_hold_a: assert property (mem_cyc_o && !mem_ack_i && !mem_err_i |=> mem_cyc_o && $stable(mem_adr_o))
    else $error("memory request not held");
  mem_drop_a: assert property (mem_cyc_o && (mem_ack_i || mem_err_i) |=> !mem_cyc_o)
    else $error("memory request not dropped");
  err_nowrite_a: assert property (
    mem_cyc_o && !mem_we_o && mem_err_i |=> !(mem_cyc_o && mem_we_o) [*8])
    else $error("write after memory error");
  read_seq_a: assert property (
    rd_done ##1 !mem_cyc_o ##1 mem_cyc_o && !mem_we_o |-> mem_adr_o == $past(mem_adr_o, 2) + 1'b1)
    else $error("reads not consecutive");
  write_seq_a: assert property (
    wr_done ##1 !mem_cyc_o ##1 mem_cyc_o && mem_we_o |-> mem_adr_o == $past(mem_adr_o, 2) + 1'b1)
    else $error("writes not consecutive");
endmodule // conv_unit_chk

bind conv_unit conv_unit_chk #(.ADDR_W(ADDR_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .mem_cyc_o(mem_cyc_o), .mem_we_o(mem_we_o), .mem_adr_o(mem_adr_o),
  .mem_ack_i(mem_ack_i), .mem_err_i(mem_err_i)
);

// file: tb/bcd_time_and_bit_column_convert_tb_top.sv
// self-checking bench for the conversion unit
// assumes conv_unit, its defines and conv_mem_model
`timescale 1ns/1ps
`include "conv_unit_defs.vh"
module bcd_time_and_bit_column_convert_tb_top;
  // ----
  // stimulus and wiring
  // ----
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc = 1'b0;
  reg         we = 1'b0;
  reg  [3:0]  sel = 4'h0;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] wdat = 32'h0;
  reg         slow = 1'b0;
  reg  [15:0] bad = 16'hffff;
  reg  [31:0] st = 32'h0;
  reg         zf = 1'b0;
  integer     failures = 0;
  integer     total_checks = 0;
  wire [31:0] rdat;
  wire        ack, m_cyc, m_we, m_ack, m_err;
  wire [15:0] m_adr, m_wd, m_rd;
  always #50 clk_i = ~clk_i;
  conv_unit u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .mem_cyc_o(m_cyc),
    .mem_we_o(m_we), .mem_adr_o(m_adr), .mem_dat_o(m_wd), .mem_dat_i(m_rd), .mem_ack_i(m_ack),
    .mem_err_i(m_err));
  conv_mem_model u_mem (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(m_cyc), .we_i(m_we), .adr_i(m_adr), .dat_i(m_wd),
    .dat_o(m_rd), .ack_o(m_ack), .err_o(m_err), .slow_i(slow), .err_adr_i(bad));
  // ----
  // shared tasks
  // ----
  task check(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h3;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 50) begin
        @(posedge clk_i);
        n = n + 1;
      end
      check({31'h0, ack}, 32'h1);
      st = rdat;
      cyc <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task ld(input [15:0] a, input [15:0] v);
    u_mem.mem[a] = v;
  endtask
  task chkm(input [15:0] a, input [15:0] v);
    check({16'h0, u_mem.mem[a]}, {16'h0, v});
  endtask
  // error keeps the zero flag as it was
  task run(input [1:0] op, input c, input [15:0] s, input [15:0] d, input [15:0] col, input e, input z);
    integer n;
    begin
      n = 0;
      wb(1'b1, `OFS_SRC, {16'h0, s});
      wb(1'b1, `OFS_DST, {16'h0, d});
      wb(1'b1, `OFS_COL, {16'h0, col});
      wb(1'b1, `OFS_CTRL, {28'h0, 1'b1, c, op});
      st = 32'h1;
      while (st[0] !== 1'b0 && n < 200) begin
        wb(1'b0, `OFS_STATUS, 32'h0);
        n = n + 1;
      end
      check({31'h0, st[0]}, 32'h0);
      if (e) z = zf;
      zf = z;
      check({30'h0, st[2:1]}, {30'h0, z, e});
    end
  endtask
  task bad_h2s(input [15:0] lo, input [15:0] hi);
    begin
      ld(16'h0900, lo);
      ld(16'h0901, hi);
      run(`OP_H2S, 1'b0, 16'h0900, 16'h0800, 16'h0, 1'b1, 1'b0);
      chkm(16'h0800, 16'h1111);
    end
  endtask
  // ----
  // scenarios
  // ----
  task t_regs;
    begin
      wb(1'b0, `OFS_STATUS, 32'h0);
      check(st, 32'h0);
      wb(1'b0, `OFS_CTRL, 32'h0);
      check(st, {30'h0, `OP_H2S});
      wb(1'b1, 8'h1c, 32'hffff);
      wb(1'b0, 8'h1c, 32'h0);
      check(st, 32'h0);
    end
  endtask
  task t_time;
    begin
      slow <= 1'b1;
      ld(16'h0100, 16'h3207);
      ld(16'h0101, 16'h2815);
      run(`OP_H2S, 1'b0, 16'h0100, 16'h0200, 16'h0, 1'b0, 1'b0);
      chkm(16'h0200, 16'h5927);
      chkm(16'h0201, 16'h1013);
      slow <= 1'b0;
      run(`OP_S2H, 1'b0, 16'h0200, 16'h0300, 16'h0, 1'b0, 1'b0);
      chkm(16'h0300, 16'h3207);
      chkm(16'h0301, 16'h2815);
    end
  endtask
  task t_limit;
    begin
      ld(16'h0100, 16'h5959);
      ld(16'h0101, 16'h9999);
      run(`OP_H2S, 1'b0, 16'h0100, 16'h0200, 16'h0, 1'b0, 1'b0);
      chkm(16'h0200, 16'h9999);
      chkm(16'h0201, 16'h3599);
      run(`OP_S2H, 1'b0, 16'h0200, 16'h0300, 16'h0, 1'b0, 1'b0);
      chkm(16'h0300, 16'h5959);
      chkm(16'h0301, 16'h9999);
      ld(16'h0200, 16'h0000);
      ld(16'h0201, 16'h3600);
      run(`OP_S2H, 1'b0, 16'h0200, 16'h0300, 16'h0, 1'b1, 1'b0);
      chkm(16'h0300, 16'h5959);
    end
  endtask
  task t_bad;
    begin
      ld(16'h0800, 16'h1111);
      bad_h2s(16'h6000, 16'h0000);
      bad_h2s(16'h0060, 16'h0000);
      bad_h2s(16'h005a, 16'h0000);
      bad_h2s(16'h0000, 16'h00a0);
      ld(16'h0901, 16'h00b0);
      run(`OP_S2H, 1'b0, 16'h0900, 16'h0800, 16'h0, 1'b1, 1'b0);
    end
  endtask
  task t_zero;
    begin
      ld(16'h0901, 16'h0000);
      ld(16'h0911, 16'h1111);
      run(`OP_H2S, 1'b0, 16'h0900, 16'h0910, 16'h0, 1'b0, 1'b1);
      chkm(16'h0911, 16'h0000);
      ld(16'h0921, 16'h1111);
      run(`OP_S2H, 1'b0, 16'h0910, 16'h0920, 16'h0, 1'b0, 1'b1);
      chkm(16'h0921, 16'h0000);
    end
  endtask
  task t_area;
    begin
      run(`OP_H2S, 1'b0, 16'h1fff, 16'h0800, 16'h0, 1'b1, 1'b0);
      ld(16'h3fff, 16'h1111);
      run(`OP_S2H, 1'b0, 16'h0900, 16'h3fff, 16'h0, 1'b1, 1'b0);
      chkm(16'h3fff, 16'h1111);
    end
  endtask
  task t_col;
    integer n;
    reg [15:0] p, e7, e15;
    begin
      for (n = 0; n < 16; n = n + 1) begin
        p = 16'h9c3b ^ (n[15:0] * 16'h1357);
        ld(16'h0500 + n[15:0], p);
        e7[n] = p[7];
        e15[n] = p[15];
      end
      run(`OP_COL, 1'b1, 16'h0500, 16'h0600, 16'h0015, 1'b0, e15 == 16'h0);
      chkm(16'h0600, e15);
      run(`OP_COL, 1'b1, 16'h0500, 16'h0601, 16'h0007, 1'b0, e7 == 16'h0);
      chkm(16'h0601, e7);
      ld(16'h0601, 16'h1111);
      run(`OP_COL, 1'b0, 16'h0500, 16'h0601, 16'h0015, 1'b0, e7 == 16'h0);
      run(`OP_COL, 1'b1, 16'h0500, 16'h0601, 16'h0016, 1'b1, 1'b0);
      run(`OP_COL, 1'b1, 16'h0500, 16'h0601, 16'h000a, 1'b1, 1'b0);
      run(`OP_COL, 1'b1, 16'h1ff8, 16'h0601, 16'h0000, 1'b1, 1'b0);
      chkm(16'h0601, 16'h1111);
      for (n = 0; n < 16; n = n + 1) begin
        ld(16'h0500 + n[15:0], 16'hfffe);
      end
      run(`OP_COL, 1'b1, 16'h0500, 16'h0602, 16'h0000, 1'b0, 1'b1);
      chkm(16'h0602, 16'h0000);
    end
  endtask
  task t_memerr;
    begin
      bad <= 16'h0901;
      run(`OP_H2S, 1'b0, 16'h0900, 16'h0800, 16'h0, 1'b1, 1'b0);
      chkm(16'h0800, 16'h1111);
      bad <= 16'hffff;
    end
  endtask
  // ----
  // verdict and sequence
  // ----
  task print_verdict;
    begin
      if (failures == 0 && total_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // roughly 700 cycles expected, about forty times that allowed
  initial begin
    #3000000;
    failures = failures + 1;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_time;
    t_limit;
    t_bad;
    t_zero;
    t_area;
    t_col;
    t_memerr;
    print_verdict;
  end
endmodule // bcd_time_and_bit_column_convert_tb_top
